//--- ivam_top.sv
// Interrupt vector address map: sources, tables and dispatch to the core
`timescale 1ns/1ps
`default_nettype none
module ivam_top (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Package strap: high on the 64-pin variant
   input wire logic pin64_variant,
   // Event inputs
   input wire logic [117:0] periph_event,
   input wire logic [7:0] trap_req,
   // Core side
   input wire logic [3:0] cpu_ipl,
   input wire logic vector_ack,
   output logic vector_valid_r,
   output logic [6:0] vector_num_r,
   output logic [23:0] vector_addr_r,
   output logic [3:0] vector_level_r,
   output logic pc_load_r,
   output logic [23:0] program_counter_r,
   // Software register port
   input wire logic sw_wr_en,
   input wire logic sw_rd_en,
   input wire logic [1:0] sw_space,
   input wire logic [4:0] sw_index,
   input wire logic [15:0] sw_wdata,
   output logic sw_rvalid_r,
   output logic [15:0] sw_rdata_r,
   // Table select state
   output logic alternate_table_select_r
);
   ////////////////////////////////////////////////////////////////////////////
   // Strap synchroniser and capture
   logic strap_meta_r;
   logic strap_sync_r;
   logic strap_taken_r;
   logic pin64_r;
   ivam_pkg::ivam_state_t state_r;
   ivam_pkg::ivam_state_t state_nxt;

   // Runs through reset so the strap is settled when it is caught
   always_ff @(posedge clock) begin
      strap_meta_r <= pin64_variant;
      strap_sync_r <= strap_meta_r;
   end

   // Caught once after reset release, after the sync chain settles
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         strap_taken_r <= 1'b0;
         pin64_r <= 1'b0;
      end else if (!strap_taken_r && state_r != ivam_pkg::ST_RESET_FETCH) begin
         strap_taken_r <= 1'b1;
         pin64_r <= strap_sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software decode
   logic wr_flag;
   logic wr_enable;
   logic wr_prio;
   logic wr_ctrl;

   assign wr_flag = sw_wr_en && sw_space == ivam_pkg::SPACE_FLAG && sw_index < 5'd8;
   assign wr_enable = sw_wr_en && sw_space == ivam_pkg::SPACE_ENABLE && sw_index < 5'd8;
   assign wr_prio = sw_wr_en && sw_space == ivam_pkg::SPACE_PRIO && sw_index < 5'd30;
   assign wr_ctrl = sw_wr_en && sw_space == ivam_pkg::SPACE_CTRL &&
      sw_index == ivam_pkg::CTRL_TWO_INDEX;

   ////////////////////////////////////////////////////////////////////////////
   // Control register two: only the table select bit is held
   logic [15:0] ctrl_two_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_two_r <= ivam_pkg::CTRL_TWO_RESET;
      end else if (wr_ctrl) begin
         ctrl_two_r <= sw_wdata & 16'h8000;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         alternate_table_select_r <= 1'b0;
      end else if (wr_ctrl) begin
         alternate_table_select_r <= sw_wdata[ivam_pkg::ALT_SEL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable and priority registers
   logic [127:0] enable_r;
   logic [15:0] prio_r [0:29];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         enable_r <= '0;
      end else if (wr_enable) begin
         enable_r[sw_index[2:0]*16 +: 16] <= sw_wdata;
      end
   end

   genvar p;
   generate
      for (p = 0; p < ivam_pkg::NUM_PRIO_REGS; p++) begin : g_prio
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               prio_r[p] <= 16'h0000;
            end else if (wr_prio && sw_index == 5'(p)) begin
               prio_r[p] <= sw_wdata & 16'h7777;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Request flags
   logic [127:0] impl_mask;
   logic [127:0] flags;
   logic [127:0] set_vec;

   // Parallel port source is missing on the 64-pin variant
   always_comb begin
      impl_mask = ivam_pkg::IMPL_MASK;
      impl_mask[ivam_pkg::PARALLEL_PORT_VEC] = !pin64_r;
   end

   assign set_vec = {10'h000, periph_event} & impl_mask;

   ivam_flag_bank u_flags (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_vec(set_vec),
      .clr_we(wr_flag),
      .clr_idx(sw_index[2:0]),
      .clr_data(sw_wdata),
      .flags(flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration
   logic [127:0] pending;
   logic [2:0] best_lvl;
   logic [6:0] best_periph;
   logic periph_found;
   logic [2:0] best_trap;
   logic trap_found;
   logic periph_wins;
   logic [2:0] src_lvl;

   assign pending = flags & enable_r & impl_mask;

   // Scan from the top so lower vectors win equal levels
   always_comb begin
      best_lvl = 3'd0;
      best_periph = 7'd0;
      periph_found = 1'b0;
      src_lvl = 3'd0;
      for (int i = ivam_pkg::NUM_PERIPH - 1; i >= 0; i--) begin
         src_lvl = prio_r[i / 4][4 * (i % 4) +: 3];
         if (pending[i] && src_lvl != 3'd0 && src_lvl >= best_lvl) begin
            best_lvl = src_lvl;
            best_periph = 7'(i);
            periph_found = 1'b1;
         end
      end
   end

   always_comb begin
      best_trap = 3'd0;
      trap_found = 1'b0;
      for (int t = ivam_pkg::NUM_TRAPS - 1; t >= 0; t--) begin
         if (trap_req[t]) begin
            best_trap = 3'(t);
            trap_found = 1'b1;
         end
      end
   end

   assign periph_wins = periph_found && !cpu_ipl[3] && best_lvl > cpu_ipl[2:0];

   ////////////////////////////////////////////////////////////////////////////
   // Address former
   ivam_vec_if vec ();

   // Traps take table index 0-7, peripheral n takes index n + 8
   always_comb begin
      if (trap_found) begin
         vec.index = {4'h0, best_trap};
      end else begin
         vec.index = best_periph + 7'd8;
      end
      vec.alt_sel = alternate_table_select_r;
   end

   ivam_vector_calc u_calc (
      .vec(vec.calc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Dispatch sequencer
   logic take;

   assign take = state_r == ivam_pkg::ST_IDLE && (trap_found || periph_wins);

   always_comb begin
      case (state_r)
         ivam_pkg::ST_RESET_FETCH: state_nxt = ivam_pkg::ST_IDLE;
         ivam_pkg::ST_IDLE: state_nxt = take ? ivam_pkg::ST_PRESENT : ivam_pkg::ST_IDLE;
         ivam_pkg::ST_PRESENT: state_nxt = vector_ack ? ivam_pkg::ST_IDLE : ivam_pkg::ST_PRESENT;
         default: state_nxt = ivam_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r <= ivam_pkg::ST_RESET_FETCH;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Reset path bypasses the controller and loads address zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pc_load_r <= 1'b0;
         program_counter_r <= ivam_pkg::RESET_ADDR;
      end else begin
         pc_load_r <= state_r == ivam_pkg::ST_RESET_FETCH;
         program_counter_r <= ivam_pkg::RESET_ADDR;
      end
   end

   // Vector held stable from take until the core acknowledges
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vector_valid_r <= 1'b0;
         vector_num_r <= 7'd0;
         vector_addr_r <= 24'h000000;
         vector_level_r <= 4'h0;
      end else if (take) begin
         vector_valid_r <= 1'b1;
         vector_num_r <= vec.index;
         vector_addr_r <= vec.addr;
         vector_level_r <= trap_found ? 4'h8 : {1'b0, best_lvl};
      end else if (state_r == ivam_pkg::ST_PRESENT && vector_ack) begin
         vector_valid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software read back
   logic [15:0] rd_word;

   always_comb begin
      rd_word = 16'h0000;
      case (sw_space)
         ivam_pkg::SPACE_FLAG: begin
            if (sw_index < 5'd8) begin
               rd_word = flags[sw_index[2:0]*16 +: 16];
            end
         end
         ivam_pkg::SPACE_ENABLE: begin
            if (sw_index < 5'd8) begin
               rd_word = enable_r[sw_index[2:0]*16 +: 16];
            end
         end
         ivam_pkg::SPACE_PRIO: begin
            if (sw_index < 5'd30) begin
               rd_word = prio_r[sw_index];
            end
         end
         ivam_pkg::SPACE_CTRL: begin
            if (sw_index == ivam_pkg::CTRL_TWO_INDEX) begin
               rd_word = ctrl_two_r;
            end
         end
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sw_rvalid_r <= 1'b0;
         sw_rdata_r <= 16'h0000;
      end else begin
         sw_rvalid_r <= sw_rd_en;
         sw_rdata_r <= sw_rd_en ? rd_word : 16'h0000;
      end
   end
endmodule
`default_nettype wire

//--- ivam_pkg.sv
// Constants for the interrupt vector address map
package ivam_pkg;
   localparam int NUM_TRAPS = 8;
   localparam int NUM_PERIPH = 118;
   localparam int NUM_FLAG_REGS = 8;
   localparam int NUM_PRIO_REGS = 30;
   localparam int ADDR_W = 24;
   localparam int VEC_W = 7;
   localparam int WORD_W = 16;
   localparam logic [23:0] TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALT_OFFSET = 24'h000100;
   localparam logic [23:0] RESET_ADDR = 24'h000000;
   localparam int ALT_SEL_BIT = 15;
   localparam int PARALLEL_PORT_VEC = 45;
   localparam int CALENDAR_CLOCK_VEC = 62;
   localparam int PIN_CHANGE_VEC = 19;
   localparam logic [127:0] IMPL_MASK =
      128'h0000_0010_3FFE_210E_4066_3FE3_FEDF_3FEF;
   localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
   localparam logic [4:0] CTRL_TWO_INDEX = 5'h00;
   typedef enum logic [1:0] {
      SPACE_FLAG = 2'b00,
      SPACE_ENABLE = 2'b01,
      SPACE_PRIO = 2'b10,
      SPACE_CTRL = 2'b11
   } ivam_space_t;
   typedef enum logic [1:0] {
      ST_RESET_FETCH = 2'b00,
      ST_IDLE = 2'b01,
      ST_PRESENT = 2'b10
   } ivam_state_t;
endpackage

//--- ivam_vec_if.sv
// Winner index and table select toward the address former
`timescale 1ns/1ps
`default_nettype none
interface ivam_vec_if;
   logic [6:0] index;
   logic alt_sel;
   logic [23:0] addr;
   modport src (output index, output alt_sel, input addr);
   modport calc (input index, input alt_sel, output addr);
endinterface
`default_nettype wire

//--- ivam_vector_calc.sv
// Combinational vector address former
`timescale 1ns/1ps
`default_nettype none
module ivam_vector_calc (
   // Winner and select in, address out
   ivam_vec_if.calc vec
);
   logic [23:0] entry_offset;
   // Same index in either table, one table sits 0x100 above
   always_comb begin
      entry_offset = {16'h0000, vec.index, 1'b0};
      vec.addr = ivam_pkg::TABLE_BASE + entry_offset;
      if (vec.alt_sel) begin
         vec.addr = ivam_pkg::TABLE_BASE + entry_offset + ivam_pkg::ALT_OFFSET;
      end
   end
endmodule
`default_nettype wire

//--- ivam_flag_bank.sv
// Request flag registers, set by events and cleared by software
`timescale 1ns/1ps
`default_nettype none
module ivam_flag_bank (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Hardware set, already masked to implemented sources
   input wire logic [127:0] set_vec,
   // Software clear: zero bits in clr_data clear flags
   input wire logic clr_we,
   input wire logic [2:0] clr_idx,
   input wire logic [15:0] clr_data,
   // Flag state
   output logic [127:0] flags
);
   genvar w;
   generate
      for (w = 0; w < ivam_pkg::NUM_FLAG_REGS; w++) begin : g_word
         logic [15:0] word_r;
         logic hit;
         assign hit = clr_we && (clr_idx == 3'(w));
         // Set wins over a clear in the same cycle
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               word_r <= 16'h0000;
            end else if (hit) begin
               word_r <= (word_r & clr_data) | set_vec[w*16 +: 16];
            end else begin
               word_r <= word_r | set_vec[w*16 +: 16];
            end
         end
         assign flags[w*16 +: 16] = word_r;
      end
   endgenerate
endmodule
`default_nettype wire

//--- ivam_top_assertions.sv
// Checker for vector dispatch, reset start and control port timing
`timescale 1ns/1ps
`default_nettype none
module ivam_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Core side
   input wire logic vector_ack,
   input wire logic vector_valid_r,
   input wire logic [6:0] vector_num_r,
   input wire logic [23:0] vector_addr_r,
   input wire logic [3:0] vector_level_r,
   input wire logic pc_load_r,
   input wire logic [23:0] program_counter_r,
   // Software port
   input wire logic sw_wr_en,
   input wire logic sw_rd_en,
   input wire logic [1:0] sw_space,
   input wire logic [4:0] sw_index,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_rvalid_r,
   input wire logic alternate_table_select_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic wbit_r;
   always_ff @(posedge clock) begin
      wbit_r <= sw_wdata[15];
   end
   a_addr_from_num: assert property (vector_valid_r |->
      vector_addr_r[7:0] == 8'h04 + {vector_num_r, 1'b0} && vector_addr_r[23:9] == 15'h0000)
      else $error("vector address does not match vector number");
   a_alt_offset: assert property ($rose(vector_valid_r) |->
      vector_addr_r[8] == $past(alternate_table_select_r))
      else $error("table offset does not follow select bit");
   a_hold_until_ack: assert property (vector_valid_r && !vector_ack |=>
      vector_valid_r && $stable(vector_addr_r) && $stable(vector_num_r))
      else $error("presented vector changed before acknowledge");
   a_drop_after_ack: assert property (vector_valid_r && vector_ack |=> !vector_valid_r)
      else $error("vector still presented after acknowledge");
   a_reset_start: assert property ($fell(sys_rst) |=> pc_load_r ##1 !pc_load_r)
      else $error("start pulse missing after reset");
   a_pc_zero: assert property (pc_load_r |-> program_counter_r == 24'h000000)
      else $error("start address is not zero");
   a_trap_level: assert property (vector_valid_r && vector_num_r < 7'h08 |->
      vector_level_r == 4'h8)
      else $error("trap vector level wrong");
   a_read_answer: assert property (sw_rd_en |=> sw_rvalid_r)
      else $error("read answer missing");
   a_select_write: assert property (sw_wr_en && sw_space == 2'h3 && sw_index == 5'h00 |=>
      alternate_table_select_r == wbit_r)
      else $error("table select not updated by write");
endmodule
bind ivam_top ivam_checker chk_u (.clock(clock), .sys_rst(sys_rst), .vector_ack(vector_ack),
   .vector_valid_r(vector_valid_r), .vector_num_r(vector_num_r), .vector_addr_r(vector_addr_r),
   .vector_level_r(vector_level_r), .pc_load_r(pc_load_r), .program_counter_r(program_counter_r),
   .sw_wr_en(sw_wr_en), .sw_rd_en(sw_rd_en), .sw_space(sw_space), .sw_index(sw_index),
   .sw_wdata(sw_wdata), .sw_rvalid_r(sw_rvalid_r),
   .alternate_table_select_r(alternate_table_select_r));
`default_nettype wire

//--- ivam_core_model.sv
// Core model: fetches the start address and accepts vectors after a set delay
`timescale 1ns/1ps
`default_nettype none
module ivam_core_model (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Start fetch
   input wire logic pc_load_r,
   input wire logic [23:0] program_counter_r,
   output logic [23:0] fetch_addr_r,
   // Vector handshake
   input wire logic vector_valid_r,
   input wire logic [3:0] ack_delay,
   input wire logic [23:0] vector_addr_r,
   output logic vector_ack,
   // Handler address read from the vector entry
   output logic [23:0] handler_addr_r
);
   logic [3:0] wait_r;
   logic ack_r;
   logic [23:0] vec_table [0:255];
   assign vector_ack = ack_r;
   // Every entry points at the default handler, alternate half mirrors default
   initial begin
      for (int e = 0; e < 128; e++) begin
         vec_table[e] = 24'h000400;
         vec_table[e + 128] = vec_table[e];
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         handler_addr_r <= 24'h000000;
      end else if (vector_valid_r && !ack_r && wait_r == ack_delay) begin
         handler_addr_r <= vec_table[vector_addr_r[8:1]];
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fetch_addr_r <= 24'hFFFFFF;
      end else if (pc_load_r) begin
         fetch_addr_r <= program_counter_r;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst || !vector_valid_r || ack_r) begin
         wait_r <= 4'h0;
         ack_r <= 1'b0;
      end else begin
         wait_r <= wait_r + 4'h1;
         ack_r <= wait_r == ack_delay;
      end
   end
endmodule
`default_nettype wire

//--- test_interrupt_vector_address_map.sv
// Self-checking bench for the vector address map
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module test_interrupt_vector_address_map;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic pin64_variant = 1'b0;
   logic [117:0] periph_event = '0;
   logic [7:0] trap_req = 8'h00;
   logic [3:0] cpu_ipl = 4'h0;
   logic sw_wr_en = 1'b0;
   logic sw_rd_en = 1'b0;
   logic [1:0] sw_space = 2'h0;
   logic [4:0] sw_index = 5'h00;
   logic [15:0] sw_wdata = 16'h0000;
   logic [3:0] ack_delay = 4'h8;
   logic vector_ack, vector_valid_r, pc_load_r, sw_rvalid_r, alternate_table_select_r;
   logic [6:0] vector_num_r;
   logic [23:0] vector_addr_r, program_counter_r, fetch_addr_r, handler_addr_r;
   logic [3:0] vector_level_r;
   logic [15:0] sw_rdata_r;
   int n_fail = 0;
   int comparisons = 0;
   always #5 clock = ~clock;
   ivam_top dut_u (.clock(clock), .sys_rst(sys_rst), .pin64_variant(pin64_variant),
      .periph_event(periph_event), .trap_req(trap_req), .cpu_ipl(cpu_ipl),
      .vector_ack(vector_ack), .vector_valid_r(vector_valid_r), .vector_num_r(vector_num_r),
      .vector_addr_r(vector_addr_r), .vector_level_r(vector_level_r), .pc_load_r(pc_load_r),
      .program_counter_r(program_counter_r), .sw_wr_en(sw_wr_en), .sw_rd_en(sw_rd_en),
      .sw_space(sw_space), .sw_index(sw_index), .sw_wdata(sw_wdata),
      .sw_rvalid_r(sw_rvalid_r), .sw_rdata_r(sw_rdata_r),
      .alternate_table_select_r(alternate_table_select_r));
   ivam_core_model core_u (.clock(clock), .sys_rst(sys_rst), .pc_load_r(pc_load_r),
      .program_counter_r(program_counter_r), .fetch_addr_r(fetch_addr_r),
      .vector_valid_r(vector_valid_r), .ack_delay(ack_delay), .vector_addr_r(vector_addr_r),
      .vector_ack(vector_ack), .handler_addr_r(handler_addr_r));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic access(input logic wr, input logic [1:0] s, input logic [4:0] i,
      input logic [15:0] d);
      sw_space = s;
      sw_index = i;
      sw_wdata = d;
      sw_wr_en = wr;
      sw_rd_en = !wr;
      tick;
      sw_wr_en = 1'b0;
      sw_rd_en = 1'b0;
   endtask
   task automatic sw_read(input logic [1:0] s, input logic [4:0] i, input logic [15:0] ex);
      access(1'b0, s, i, 16'h0000);
      `CHK("sw_rvalid_r", 1'b1, sw_rvalid_r)
      `CHK("sw_rdata_r", ex, sw_rdata_r)
   endtask
   task automatic pulse(input int n);
      periph_event[n] = 1'b1;
      tick;
      periph_event = '0;
   endtask
   // Waits for a vector, checks it, clears its source, waits for release
   task automatic expect_vec(input logic [6:0] n, input logic [23:0] a, input logic [3:0] l);
      int k;
      logic [6:0] m;
      m = n - 7'h08;
      for (k = 0; k < 30 && vector_valid_r !== 1'b1; k++) tick;
      `CHK("vector_num_r", n, vector_num_r)
      `CHK("vector_addr_r", a, vector_addr_r)
      `CHK("vector_level_r", l, vector_level_r)
      if (n < 7'h08) trap_req = 8'h00;
      else access(1'b1, 2'h0, {2'h0, m[6:4]}, ~(16'h0001 << m[3:0]));
      for (k = 0; k < 30 && vector_valid_r !== 1'b0; k++) tick;
      `CHK("vector_valid_r", 1'b0, vector_valid_r)
      `CHK("handler_addr_r", 24'h000400, handler_addr_r)
   endtask
   // Mid-run reset with a new strap, then vector 45 enabled at level 5
   task automatic restart(input logic strap);
      pin64_variant = strap;
      sys_rst = 1'b1;
      repeat (6) tick;
      sys_rst = 1'b0;
      tick;
      `CHK("pc_load_r", 1'b1, pc_load_r)
      tick;
      access(1'b1, 2'h1, 5'h02, 16'h2000);
      access(1'b1, 2'h2, 5'h0B, 16'h0050);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      tick;
      `CHK("pc_load_r", 1'b1, pc_load_r)
      `CHK("program_counter_r", 24'h000000, program_counter_r)
      tick;
      `CHK("pc_load_r", 1'b0, pc_load_r)
      `CHK("fetch_addr_r", 24'h000000, fetch_addr_r)
      sw_read(2'h3, 5'h00, 16'h0000);
      sw_read(2'h2, 5'h1E, 16'h0000);
      $display("t_reset done");
   endtask
   task automatic t_pin_change;
      access(1'b1, 2'h1, 5'h01, 16'h0018);
      access(1'b1, 2'h2, 5'h04, 16'h3000);
      access(1'b1, 2'h2, 5'h05, 16'h0003);
      periph_event[19] = 1'b1;
      periph_event[20] = 1'b1;
      tick;
      periph_event = '0;
      sw_read(2'h0, 5'h01, 16'h0018);
      expect_vec(7'h1B, 24'h00003A, 4'h3);
      expect_vec(7'h1C, 24'h00003C, 4'h3);
      sw_read(2'h0, 5'h01, 16'h0000);
      $display("t_pin_change done");
   endtask
   task automatic t_alt_table;
      access(1'b1, 2'h3, 5'h00, 16'hFFFF);
      sw_read(2'h3, 5'h00, 16'h8000);
      access(1'b1, 2'h1, 5'h03, 16'h4000);
      access(1'b1, 2'h2, 5'h0F, 16'h0200);
      ack_delay = 4'h2;
      pulse(62);
      expect_vec(7'h46, 24'h000190, 4'h2);
      pulse(19);
      expect_vec(7'h1B, 24'h00013A, 4'h3);
      access(1'b1, 2'h3, 5'h00, 16'h0000);
      pulse(19);
      expect_vec(7'h1B, 24'h00003A, 4'h3);
      $display("t_alt_table done");
   endtask
   task automatic t_traps;
      int t;
      logic [23:0] a;
      for (t = 0; t < 8; t++) begin
         access(1'b1, 2'h3, 5'h00, {t[0], 15'h0000});
         trap_req[t] = 1'b1;
         a = 24'h000004 + 24'(2 * t) + (t[0] ? 24'h000100 : 24'h000000);
         expect_vec(7'(t), a, 4'h8);
      end
      access(1'b1, 2'h3, 5'h00, 16'h0000);
      $display("t_traps done");
   endtask
   task automatic t_masked;
      restart(1'b1);
      pulse(45);
      repeat (8) tick;
      `CHK("vector_valid_r", 1'b0, vector_valid_r)
      sw_read(2'h0, 5'h02, 16'h0000);
      restart(1'b0);
      cpu_ipl = 4'h5;
      pulse(45);
      repeat (8) tick;
      cpu_ipl = 4'h4;
      expect_vec(7'h35, 24'h00006E, 4'h5);
      $display("t_masked done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      t_reset;
      t_pin_change;
      t_alt_table;
      t_traps;
      t_masked;
      end_of_test;
   end
endmodule
`default_nettype wire
